// file: src/dmx_access.sv
// Data-memory and external-bus access logic: scratchpad and auxiliary RAM,
// external program/data bus strobes, extra 4-bit port.
// Assumes Wishbone classic master, pins synchronised here, 50 MHz clock.
//
// How it works
// RL1 - With external-access pin high, no fetch address or data on bus.
// RL2 - Program store strobe pulses only for external program reads.
// RL3 - Address latch enable runs at one sixth of the oscillator rate; code skips the state-3 pulse in each external data cycle.
// RL4 - Reset held two machine cycles; then everything resets fully. Code keeps the RAM contents.
// RL5 - High address port carries upper address during external accesses.
// RL6 - 512 bytes internal RAM: scratchpad bank and auxiliary bank.
// RL7 - Scratchpad 00-7f reachable directly and indirectly.
// RL8 - Scratchpad 80-ff reachable only indirectly.
// RL9 - Auxiliary RAM reached only by external-data moves, 8 or 16 bit pointer.
// RL10 - External-data moves above ff always use the external bus.
// RL11 - Auxiliary RAM disabled after reset.
// RL12 - Chip control bit 4 enables the auxiliary RAM.
// RL13 - Enabled: 8-bit pointer external-data moves hit auxiliary RAM.
// RL14 - Auxiliary RAM access leaves ports and read/write strobes untouched.
// RL15 - Oscillator divided by two before internal use.
// RL16 - Extra 4-bit port, quasi-bidirectional like port 1.
// RL17 - Software unlocks with 87 then 59 before chip control writes.
// RL18 - Reset sets ports to ff, most registers to 00.
`timescale 1ns/100ps
module dmx_access
  import dmx_pkg::*;
#(
  parameter int ADDR_IDX_W = 8
) (
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Pins
  input  wire logic        external_access_pin_i,
  input  wire logic [7:0]  low_address_data_port_i,
  output logic      [7:0]  low_address_data_port_o,
  output logic             low_address_data_port_oe_o,
  output logic      [7:0]  high_address_port_o,
  output logic             address_latch_enable_o,
  output logic             program_store_strobe_n_o,
  output logic             read_strobe_n_o,
  output logic             write_strobe_n_o,
  input  wire logic [3:0]  extra_port_i,
  output logic      [3:0]  extra_port_o,
  output logic      [3:0]  extra_port_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic       pin_meta, pin_sync;
  logic [7:0] low_meta, low_sync;
  logic [3:0] xp_meta, xp_sync;

  always_ff @(posedge sys_clk_i) begin
    pin_meta <= external_access_pin_i;
    pin_sync <= pin_meta;
    low_meta <= low_address_data_port_i;
    low_sync <= low_meta;
    xp_meta  <= extra_port_i;
    xp_sync  <= xp_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock division: half-rate phase, then six states per machine cycle
  logic       phase;
  logic [2:0] state_cnt;
  wire        state_tick = phase;
  wire        cycle_end  = state_tick && (state_cnt == 3'(DMX_STATES_PER_CYCLE - 1));

  // RL15 divide by two
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      phase     <= 1'b0;
      state_cnt <= 3'h0;
    end else begin
      phase <= ~phase;
      if (state_tick) begin
        state_cnt <= cycle_end ? 3'h0 : state_cnt + 3'h1;
      end
    end
  end

  // RL3 two pulses per six states
  wire ale_now = (state_cnt == 3'h0) || (state_cnt == 3'h3);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] chip_control;
  logic [3:0] extra_port_data;
  logic [1:0] key_stage;
  logic [7:0] access_ctrl;
  logic [15:0] access_addr;
  logic [7:0] access_data;
  logic [7:0] ram_pointer;
  logic       busy;
  logic       done;

  wire [ADDR_IDX_W-1:0] idx    = wb_adr_i[ADDR_IDX_W+1:2];
  wire                  req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire                  wr_lo  = req && wb_we_i && wb_sel_i[0];
  wire                  hit_cc = idx == DMX_IDX_CHIP_CONTROL;
  wire                  hit_xp = idx == DMX_IDX_EXTRA_PORT;
  wire                  hit_ky = idx == DMX_IDX_CHIP_ENABLE_KEY;
  wire                  hit_ac = idx == DMX_IDX_ACCESS_CTRL;
  wire                  hit_aa = idx == DMX_IDX_ACCESS_ADDR;
  wire                  hit_ad = idx == DMX_IDX_ACCESS_DATA;
  wire                  hit_as = idx == DMX_IDX_ACCESS_STATUS;
  wire                  hit_rp = idx == DMX_IDX_RAM_POINTER;
  wire                  mapped = hit_cc | hit_xp | hit_ky | hit_ac | hit_aa | hit_ad | hit_as | hit_rp;
  wire                  unlocked = key_stage == 2'h2;
  wire                  aux_en   = chip_control[DMX_AUX_EN_BIT];
  wire                  start    = wr_lo && hit_ac && !busy;

  // RL17 key sequence gates chip control
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      key_stage <= 2'h0;
    end else if (wr_lo && hit_ky) begin
      if (wb_dat_i[7:0] == DMX_KEY_FIRST) begin
        key_stage <= 2'h1;
      end else if (wb_dat_i[7:0] == DMX_KEY_SECOND && key_stage == 2'h1) begin
        key_stage <= 2'h2;
      end else begin
        key_stage <= 2'h0;
      end
    end
  end

  // RL11 RL18 reset values
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      chip_control    <= DMX_CHIP_CONTROL_RST;
      extra_port_data <= DMX_EXTRA_PORT_RST;
      access_ctrl     <= 8'h00;
      access_addr     <= 16'h0000;
      ram_pointer     <= 8'h00;
    end else begin
      // RL12 bit 4 enables auxiliary
      if (wr_lo && hit_cc && unlocked) chip_control <= wb_dat_i[7:0];
      // RL16 only low four bits
      if (wr_lo && hit_xp) extra_port_data <= wb_dat_i[3:0] & DMX_EXTRA_PORT_MASK;
      if (start) access_ctrl <= wb_dat_i[7:0];
      if (wr_lo && hit_aa && !busy) access_addr[7:0] <= wb_dat_i[7:0];
      if (req && wb_we_i && wb_sel_i[1] && hit_aa && !busy) access_addr[15:8] <= wb_dat_i[15:8];
      if (wr_lo && hit_rp) ram_pointer <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access routing
  dmx_kind_type kind;
  assign kind = dmx_kind_type'(access_ctrl[DMX_ACC_KIND_LSB +: 2]);
  wire acc_write = access_ctrl[DMX_ACC_WRITE_BIT];
  wire is_movx   = (kind == DMX_KIND_MOVX_8BIT) || (kind == DMX_KIND_MOVX_16BIT);
  // RL13 RL10 8-bit pointer or 16-bit below 100 go to auxiliary when enabled
  wire to_aux    = aux_en && ((kind == DMX_KIND_MOVX_8BIT) ||
                   (kind == DMX_KIND_MOVX_16BIT && access_addr[15:8] == 8'h00));
  wire to_ext    = is_movx && !to_aux;
  // RL8 direct access above 7f refused
  wire refused   = (kind == DMX_KIND_SCRATCH_DIRECT) && access_addr[7];

  // RL6 RL7 RL9 bank select is bit 8
  wire        ram_sel  = !is_movx || to_aux;
  wire        ram_bank = is_movx;
  wire        ram_we   = busy && state_tick && state_cnt == 3'h0 && ram_sel && acc_write && !refused;
  wire [8:0]  ram_addr = {ram_bank, access_addr[7:0]};
  logic [7:0] ram_rdata;

  dmx_ram #(.AW(9), .DW(8)) u_ram (
    .sys_clk_i (sys_clk_i),
    .we_i      (ram_we),
    .addr_i    (ram_addr),
    .wdata_i   (access_data),
    .rdata_o   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer: one machine cycle per access, aligned to cycle start
  logic       armed;
  // Arm on the last state so busy covers state 0 with its latch pulse
  wire        cyc_start = cycle_end;
  wire        host_wr_data = wr_lo && hit_ad && !busy;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      busy        <= 1'b0;
      armed       <= 1'b0;
      done        <= 1'b0;
      access_data <= 8'h00;
    end else begin
      if (host_wr_data) access_data <= wb_dat_i[7:0];
      if (start) begin
        armed <= 1'b1;
        done  <= 1'b0;
      end else if (armed && cyc_start) begin
        armed <= 1'b0;
        busy  <= 1'b1;
      end else if (busy && cycle_end) begin
        busy <= 1'b0;
        done <= 1'b1;
        if (!acc_write && !refused) access_data <= to_ext ? low_sync : ram_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External bus
  // RL1 fetches only when pin low; RL2 strobe only then
  wire        ext_fetch = !pin_sync && !busy;
  wire        ext_data  = busy && to_ext;
  wire        late      = state_cnt >= 3'h3;
  dmx_bus_type next_bus;

  always_comb begin
    next_bus                 = '{low_out: DMX_PORT_RST, low_oe: 1'b0, high_out: DMX_PORT_RST,
                                 ale: 1'b0, program_store_n: 1'b1, read_n: 1'b1, write_n: 1'b1};
    // RL14 auxiliary access leaves ports and strobes idle; ALE keeps running
    if (ext_data) begin
      // RL5 upper address on high port
      next_bus.high_out = (kind == DMX_KIND_MOVX_16BIT) ? access_addr[15:8] : DMX_PORT_RST;
      next_bus.ale      = state_cnt == 3'h0;
      next_bus.low_oe   = !late || acc_write;
      next_bus.low_out  = late ? access_data : access_addr[7:0];
      next_bus.read_n   = !(late && !acc_write);
      next_bus.write_n  = !(late && acc_write);
    end else if (ext_fetch) begin
      next_bus.high_out        = ram_pointer;
      next_bus.ale             = ale_now;
      next_bus.low_oe          = ale_now;
      next_bus.low_out         = ram_pointer;
      next_bus.program_store_n = ale_now;
    end else begin
      // RL3 latch enable keeps running
      next_bus.ale = ale_now;
    end
  end

  // RL4 RL18 ports to ff during reset
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      low_address_data_port_o    <= DMX_PORT_RST;
      low_address_data_port_oe_o <= 1'b0;
      high_address_port_o        <= DMX_PORT_RST;
      address_latch_enable_o     <= 1'b0;
      program_store_strobe_n_o   <= 1'b1;
      read_strobe_n_o            <= 1'b1;
      write_strobe_n_o           <= 1'b1;
    end else begin
      low_address_data_port_o    <= next_bus.low_out;
      low_address_data_port_oe_o <= next_bus.low_oe;
      high_address_port_o        <= next_bus.high_out;
      address_latch_enable_o     <= next_bus.ale;
      program_store_strobe_n_o   <= next_bus.program_store_n;
      read_strobe_n_o            <= next_bus.read_n;
      write_strobe_n_o           <= next_bus.write_n;
    end
  end

  // RL16 quasi-bidirectional: drive only zeros, pull-up gives ones
  assign extra_port_o    = extra_port_data;
  assign extra_port_oe_o = ~extra_port_data;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer, one cycle after the request, error on unmapped index
  wire [7:0] status  = {5'h00, aux_en, busy | armed, done};
  wire [31:0] rd_mux = hit_cc ? {24'h0, chip_control} :
                       hit_xp ? {28'h0, xp_sync} :
                       hit_ac ? {24'h0, access_ctrl} :
                       hit_aa ? {16'h0, access_addr} :
                       hit_ad ? {24'h0, access_data} :
                       hit_as ? {24'h0, status} :
                       hit_rp ? {24'h0, ram_pointer} : 32'h0;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h0;
    end
  end

endmodule : dmx_access

// file: src/dmx_pkg.sv
// Package for the data-memory and external-bus access block.
// Assumes a single 50 MHz clock and a classic Wishbone register port.
package dmx_pkg;

  // Register indices, byte address is four times the index
  localparam logic [7:0]  DMX_IDX_CHIP_CONTROL   = 8'hbf;
  localparam logic [7:0]  DMX_IDX_EXTRA_PORT     = 8'hd8;
  localparam logic [7:0]  DMX_IDX_CHIP_ENABLE_KEY = 8'hf6;
  localparam logic [7:0]  DMX_IDX_ACCESS_CTRL    = 8'h00;
  localparam logic [7:0]  DMX_IDX_ACCESS_ADDR    = 8'h01;
  localparam logic [7:0]  DMX_IDX_ACCESS_DATA    = 8'h02;
  localparam logic [7:0]  DMX_IDX_ACCESS_STATUS  = 8'h03;
  localparam logic [7:0]  DMX_IDX_RAM_POINTER    = 8'h04;

  // Field positions
  localparam int          DMX_AUX_EN_BIT         = 4;
  localparam logic [3:0]  DMX_EXTRA_PORT_MASK    = 4'hf;

  // Access control fields (write strobes a request)
  localparam int          DMX_ACC_WRITE_BIT      = 0;
  localparam int          DMX_ACC_KIND_LSB       = 1;

  // Reset values and unlock key bytes
  localparam logic [7:0]  DMX_CHIP_CONTROL_RST   = 8'h00;
  localparam logic [3:0]  DMX_EXTRA_PORT_RST     = 4'hf;
  localparam logic [7:0]  DMX_PORT_RST           = 8'hff;
  localparam logic [7:0]  DMX_KEY_FIRST          = 8'h87;
  localparam logic [7:0]  DMX_KEY_SECOND         = 8'h59;

  // Timing: internal clock is oscillator divided by two, six states of two phases each
  localparam int          DMX_PHASES_PER_STATE   = 2;
  localparam int          DMX_STATES_PER_CYCLE   = 6;
  localparam int          DMX_OSC_PER_CYCLE      = DMX_PHASES_PER_STATE * DMX_STATES_PER_CYCLE;
  localparam int          DMX_ALE_PER_CYCLE      = 2;
  localparam int          DMX_RESET_MIN_CYCLES   = 2;

  typedef enum logic [1:0] {
    DMX_KIND_SCRATCH_DIRECT,
    DMX_KIND_SCRATCH_INDIRECT,
    DMX_KIND_MOVX_8BIT,
    DMX_KIND_MOVX_16BIT
  } dmx_kind_type;

  // Bus request toward the external memories
  typedef struct packed {
    logic [7:0] low_out;
    logic       low_oe;
    logic [7:0] high_out;
    logic       ale;
    logic       program_store_n;
    logic       read_n;
    logic       write_n;
  } dmx_bus_type;

endpackage : dmx_pkg

// file: src/dmx_ram.sv
// Dual 256-byte bank memory, one port, registered read data.
// Assumes the caller presents one access per cycle at most.
`timescale 1ns/100ps
module dmx_ram #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input  wire logic          sys_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents are not reset, as in the real array
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule : dmx_ram

// file: tb/dmx_access_checker.sv
// Port-level assertions for dmx_access.
// Assumes one clock domain and the synchronous reset srst_i.
`timescale 1ns/100ps
module dmx_access_checker
  import dmx_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_ack_o,
  input  wire logic       wb_err_o,
  input  wire logic       external_access_pin_i,
  input  wire logic       low_address_data_port_oe_o,
  input  wire logic [7:0] high_address_port_o,
  input  wire logic       address_latch_enable_o,
  input  wire logic       program_store_strobe_n_o,
  input  wire logic       read_strobe_n_o,
  input  wire logic       write_strobe_n_o,
  input  wire logic [3:0] extra_port_o,
  input  wire logic [3:0] extra_port_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Pin sync delay plus a fetch in flight stays below 20 clocks
  logic [4:0] pin_hi_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !external_access_pin_i)
      pin_hi_cnt <= 5'h00;
    else if (pin_hi_cnt != 5'h1f)
      pin_hi_cnt <= pin_hi_cnt + 5'h01;
  end
  ////////////////////////////////////////////////////////////
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered next cycle");
  a_no_fetch_pin: assert property (pin_hi_cnt >= 5'd20 |-> program_store_strobe_n_o)
    else $error("fetch strobe with access pin high");
  a_program_store_strobe_not_data: assert property (!read_strobe_n_o |-> program_store_strobe_n_o && write_strobe_n_o)
    else $error("program strobe during data read");
  a_ale_strobe_apart: assert property (address_latch_enable_o |-> read_strobe_n_o && write_strobe_n_o)
    else $error("ALE overlaps a strobe");
  a_read_six: assert property ($fell(read_strobe_n_o) |-> !read_strobe_n_o [*6] ##1 read_strobe_n_o)
    else $error("read strobe length wrong");
  a_write_six: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*6] ##1 write_strobe_n_o)
    else $error("write strobe length wrong");
  a_write_drives: assert property (!write_strobe_n_o |-> low_address_data_port_oe_o)
    else $error("write data not driven");
  a_read_released: assert property (!read_strobe_n_o |-> !low_address_data_port_oe_o)
    else $error("low port driven during read");
  a_extra_quasi: assert property (extra_port_oe_o == ~extra_port_o)
    else $error("extra port drives a high");
  a_reset_state: assert property (disable iff (1'b0) srst_i |=> high_address_port_o == DMX_PORT_RST
    && extra_port_o == DMX_EXTRA_PORT_RST && !address_latch_enable_o && !wb_ack_o && program_store_strobe_n_o)
    else $error("outputs not reset");
  c_err: cover property (wb_err_o);
  c_wr: cover property ($fell(write_strobe_n_o));
  c_rd: cover property ($fell(read_strobe_n_o));
  c_fetch: cover property ($fell(program_store_strobe_n_o));
endmodule : dmx_access_checker

bind dmx_access dmx_access_checker chk_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .external_access_pin_i(external_access_pin_i),
  .low_address_data_port_oe_o(low_address_data_port_oe_o), .high_address_port_o(high_address_port_o),
  .address_latch_enable_o(address_latch_enable_o), .program_store_strobe_n_o(program_store_strobe_n_o),
  .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o), .extra_port_o(extra_port_o),
  .extra_port_oe_o(extra_port_oe_o));

// file: tb/dmx_ext_mem.sv
// External program ROM and data memory on the multiplexed bus pins.
// Assumes active-low strobes and an address latched while ALE is high.
`timescale 1ns/100ps
module dmx_ext_mem (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] low_i,
  input  wire logic       low_oe_i,
  input  wire logic [7:0] high_i,
  input  wire logic       ale_i,
  input  wire logic       prog_strobe_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  output logic      [7:0] data_o = 8'h00
);
  logic [7:0]  mem [int];
  logic [15:0] addr = 16'h0000;
  ////////////////////////////////////////////////////////////
  // latch address, store writes
  always @(posedge sys_clk_i) begin
    if (ale_i && low_oe_i)
      addr <= {high_i, low_i};
    if (!wr_n_i && low_oe_i)
      mem[addr] = low_i;
    // Released bus toggles so a stale value never passes
    if (!rd_n_i)
      data_o <= mem.exists(addr) ? mem[addr] : ~addr[7:0];
    else if (!prog_strobe_n_i)
      data_o <= addr[7:0];
    else
      data_o <= ~data_o;
  end
endmodule : dmx_ext_mem

// file: tb/tb_dmx_access.sv
// Self-checking bench for dmx_access over Wishbone.
// Assumes dmx_ext_mem answers on the bus pins.
`timescale 1ns/100ps
module tb_dmx_access;
  import dmx_pkg::*;
  logic        sys_clk_i = 0;
  logic        srst_i = 1;
  logic        cyc = 0;
  logic        we = 0;
  logic        fetch_off = 1;
  logic        e;
  logic [7:0]  idx = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q, v;
  logic        ack, err, ale, ps_n, rd_n, wr_n, oe;
  logic [7:0]  lo_o, lo_i, hi, hi_seen;
  logic [3:0]  xo, xoe;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          wr_cnt = 0, rd_cnt = 0, ps_cnt = 0, ale_cnt = 0, n0, n1;
  logic        ale_q = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  dmx_access dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i({2'b00, idx, 2'b00}), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .external_access_pin_i(fetch_off), .low_address_data_port_i(lo_i),
    .low_address_data_port_o(lo_o),
    .low_address_data_port_oe_o(oe), .high_address_port_o(hi), .address_latch_enable_o(ale),
    .program_store_strobe_n_o(ps_n), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .extra_port_i(~xoe),
    .extra_port_o(xo), .extra_port_oe_o(xoe));
  dmx_ext_mem mem_u (.sys_clk_i(sys_clk_i), .low_i(lo_o), .low_oe_i(oe), .high_i(hi), .ale_i(ale),
    .prog_strobe_n_i(ps_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_o(lo_i));
  // Counters update late so reads at the same edge see a stable value
  always @(posedge sys_clk_i) begin
    ale_q <= ale;
    if (ale && !ale_q) ale_cnt <= ale_cnt + 1;
    if (!ps_n) ps_cnt <= ps_cnt + 1;
    if (!rd_n) rd_cnt <= rd_cnt + 1;
    if (!wr_n) wr_cnt <= wr_cnt + 1;
    if (!wr_n) hi_seen <= hi;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    cyc <= 1;
    we <= w;
    idx <= i;
    wdat <= d;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdat;
    e = err;
    cyc <= 0;
    if (n >= 20) miscompares++;
  endtask : wb
  task automatic acc(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    wb(1, DMX_IDX_ACCESS_ADDR, {16'h0, a});
    wb(1, DMX_IDX_ACCESS_DATA, {24'h0, d});
    wb(1, DMX_IDX_ACCESS_CTRL, {29'h0, k, w});
    n = 0;
    do begin
      wb(0, DMX_IDX_ACCESS_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b1 && n < 40);
    wb(0, DMX_IDX_ACCESS_DATA, 32'h0);
  endtask : acc
  task automatic ctl(input logic [7:0] c);
    wb(1, DMX_IDX_CHIP_ENABLE_KEY, {24'h0, DMX_KEY_FIRST});
    wb(1, DMX_IDX_CHIP_ENABLE_KEY, {24'h0, DMX_KEY_SECOND});
    wb(1, DMX_IDX_CHIP_CONTROL, {24'h0, c});
    wb(1, DMX_IDX_CHIP_ENABLE_KEY, 32'h0);
  endtask : ctl
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    results();
  end
  initial begin
    void'($urandom(37));
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 0;
    wb(0, DMX_IDX_CHIP_CONTROL, 32'h0);
    chk("chip_control", q, 32'h0);
    chk("high_port", 32'(hi), 32'hff);
    wb(0, 8'h40, 32'h0);
    chk("unmapped_err", 32'(e), 32'h1);
    $display("test reset done");
    n0 = wr_cnt;
    acc(DMX_KIND_MOVX_8BIT, 1, 16'h0033, 8'h5a);
    chk("ext_write", 32'(wr_cnt > n0), 32'h1);
    acc(DMX_KIND_MOVX_16BIT, 1, 16'h1234, 8'h6c);
    chk("high_byte", 32'(hi_seen), 32'h12);
    acc(DMX_KIND_MOVX_16BIT, 0, 16'h1234, 8'h00);
    chk("ext_read", q, 32'h6c);
    $display("test external done");
    wb(1, DMX_IDX_CHIP_CONTROL, 32'h10);
    wb(0, DMX_IDX_CHIP_CONTROL, 32'h0);
    chk("locked", 32'(q[DMX_AUX_EN_BIT]), 32'h0);
    ctl(8'h10);
    wb(0, DMX_IDX_ACCESS_STATUS, 32'h0);
    chk("aux_on", 32'(q[2]), 32'h1);
    n0 = wr_cnt;
    n1 = rd_cnt;
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      acc(i[0] ? DMX_KIND_MOVX_16BIT : DMX_KIND_MOVX_8BIT, 1, {8'h00, v[15:8]}, v[7:0]);
      acc(DMX_KIND_MOVX_8BIT, 0, {8'h00, v[15:8]}, 8'h00);
      chk("aux_data", q, 32'(v[7:0]));
    end
    chk("aux_quiet", 32'(wr_cnt - n0 + rd_cnt - n1), 32'h0);
    acc(DMX_KIND_MOVX_8BIT, 1, 16'h0033, 8'ha5);
    acc(DMX_KIND_SCRATCH_INDIRECT, 1, 16'h0033, 8'hc3);
    acc(DMX_KIND_MOVX_8BIT, 0, 16'h0033, 8'h00);
    chk("banks_apart", q, 32'ha5);
    $display("test aux done");
    acc(DMX_KIND_SCRATCH_INDIRECT, 1, 16'h0080, 8'h3e);
    acc(DMX_KIND_SCRATCH_DIRECT, 1, 16'h0080, 8'h99);
    acc(DMX_KIND_SCRATCH_INDIRECT, 0, 16'h0080, 8'h00);
    chk("upper_scratch", q, 32'h3e);
    acc(DMX_KIND_SCRATCH_DIRECT, 1, 16'h007f, 8'h47);
    acc(DMX_KIND_SCRATCH_INDIRECT, 0, 16'h007f, 8'h00);
    chk("lower_scratch", q, 32'h47);
    $display("test scratch done");
    ctl(8'h00);
    acc(DMX_KIND_MOVX_8BIT, 0, 16'h0033, 8'h00);
    chk("aux_off", q, 32'h5a);
    fetch_off <= 0;
    repeat (24) @(posedge sys_clk_i);
    n0 = ale_cnt;
    n1 = ps_cnt;
    repeat (120) @(posedge sys_clk_i);
    chk("ale_rate", 32'(ale_cnt - n0), 32'd20);
    chk("fetch_strobe", 32'(ps_cnt > n1), 32'h1);
    fetch_off <= 1;
    repeat (30) @(posedge sys_clk_i);
    n1 = ps_cnt;
    repeat (60) @(posedge sys_clk_i);
    chk("no_fetch", 32'(ps_cnt - n1), 32'h0);
    $display("test fetch done");
    repeat (3) begin
      v = $urandom;
      wb(1, DMX_IDX_EXTRA_PORT, v);
      chk("extra_out", 32'(xo), 32'(v[3:0]));
      repeat (4) @(posedge sys_clk_i);
      wb(0, DMX_IDX_EXTRA_PORT, 32'h0);
      chk("extra_in", 32'(q[3:0]), 32'(v[3:0]));
    end
    ctl(8'h10);
    srst_i <= 1;
    repeat (24) @(posedge sys_clk_i);
    srst_i <= 0;
    wb(0, DMX_IDX_CHIP_CONTROL, 32'h0);
    chk("rereset", q, 32'h0);
    chk("extra_reset", 32'(xo), 32'hf);
    $display("test port and reset done");
    results();
  end
endmodule : tb_dmx_access
